// ===== rtl/can_setup_pkg.sv
package can_setup_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 4;

    // straps settle this long after reset release before they are captured
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // led blink half period and per-rate listening window
    localparam int BLINK_HALF_MS = 50;
    localparam int BLINK_HALF_CYC = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
    localparam int DWELL_MS = 100;
    localparam int DWELL_CYC = (DWELL_MS * 1000000) / CLK_PERIOD_NS;

    // bit rate selection codes
    localparam logic [3:0] RATE_AUTO = 4'h0;
    localparam logic [3:0] RATE_MIN = 4'h1;
    localparam logic [3:0] RATE_MAX = 4'h8;
    localparam logic [3:0] RATE_DEFAULT = 4'h6;

    // node identifier range
    localparam logic [6:0] NODE_ID_MIN = 7'h01;
    localparam logic [6:0] NODE_ID_MAX = 7'h7E;

    // first firmware revision with automatic detection (decimal 3102)
    localparam logic [15:0] FW_AUTO_MIN = 16'h0C1E;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_DWELL = 8'h0C;

    // status register fields
    localparam int STAT_RATE_LSB = 0;
    localparam int STAT_ID_LSB = 4;
    localparam int STAT_STATE_LSB = 12;
    localparam int STAT_AUTO_BIT = 16;

    // interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_LOCK = 0;
    localparam int IRQ_BOOT = 1;
    localparam int IRQ_ADDR = 2;
    localparam int IRQ_RETRY = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b000,
        ST_SELECT = 3'b001,
        ST_DETECT = 3'b011,
        ST_BOOT = 3'b010,
        ST_PREOP = 3'b110,
        ST_ADDR_ERR = 3'b100
    } setup_state_type;

endpackage : can_setup_pkg

// ===== rtl/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer #(
    parameter int unsigned PERIOD = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [31:0] count_ff;
    wire last = (count_ff == PERIOD - 1);
    wire [31:0] nxt_count = last ? 32'h0000_0000 : count_ff + 32'h0000_0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 32'h0000_0000;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign tick = last;
endmodule : pulse_timer

// ===== rtl/can_node_rate_and_id_setup.sv
`timescale 1ns/1ps
module can_node_rate_and_id_setup
    import can_setup_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC,
    parameter logic [31:0] DWELL_RESET = DWELL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [3:0] bit_rate_select,
    input wire logic [6:0] node_id_select,
    input wire logic [15:0] fw_revision,
    input wire logic rx_frame_ok,
    input wire logic rx_frame_err,
    input wire logic boot_tx_ready,
    output logic [3:0] bit_rate_code,
    output logic listen_only,
    output logic tx_enable,
    output logic boot_tx_valid,
    output logic [6:0] boot_tx_node_id,
    output logic preop_state,
    output logic run_led,
    output logic fault_led,
    output logic address_error_display
);

    function automatic logic id_valid(input logic [6:0] id);
        id_valid = (id >= NODE_ID_MIN) && (id <= NODE_ID_MAX);
    endfunction : id_valid

    function automatic logic rate_manual(input logic [3:0] code);
        rate_manual = (code >= RATE_MIN) && (code <= RATE_MAX);
    endfunction : rate_manual

    // pin synchronisers; straps are static, so a per-bit two-flop is enough
    logic [26:0] pin_meta_ff;
    logic [26:0] pin_sync_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 27'h000_0000;
            pin_sync_ff <= 27'h000_0000;
        end else begin
            pin_meta_ff <= {fw_revision, node_id_select, bit_rate_select};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    wire [3:0] sel_sync = pin_sync_ff[3:0];
    wire [6:0] id_sync = pin_sync_ff[10:4];
    wire [15:0] rev_sync = pin_sync_ff[26:11];

    setup_state_type state_ff;
    setup_state_type nxt_state;
    logic [7:0] settle_ff;
    logic [3:0] rate_ff;
    logic [3:0] nxt_rate;
    logic [6:0] node_id_ff;
    logic auto_ff;
    logic [31:0] dwell_cnt_ff;
    logic [31:0] dwell_ff;
    logic phase_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic blink_tick;

    pulse_timer #(
        .PERIOD(BLINK_CYCLES)
    ) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .tick(blink_tick)
    );

    // straps are sampled exactly once, in the select state
    wire settle_done = (settle_ff == STRAP_SETTLE_CYC[7:0]);
    wire in_select = (state_ff == ST_SELECT);
    wire in_detect = (state_ff == ST_DETECT);
    wire auto_allowed = (rev_sync >= FW_AUTO_MIN);
    wire want_auto = (sel_sync == RATE_AUTO) && auto_allowed;
    wire [3:0] fixed_rate = rate_manual(sel_sync) ? sel_sync : RATE_DEFAULT;
    wire dwell_over = (dwell_cnt_ff >= dwell_ff);
    wire lock_ev = in_detect && rx_frame_ok;
    wire retry_ev = in_detect && !rx_frame_ok && (rx_frame_err || dwell_over);
    wire [3:0] rate_next_try = (rate_ff == RATE_MAX) ? RATE_MIN : rate_ff + 4'h1;
    wire boot_done = (state_ff == ST_BOOT) && boot_tx_ready;
    wire addr_ev = in_select && !id_valid(id_sync);

    always_comb begin
        nxt_state = state_ff;
        nxt_rate = rate_ff;
        unique case (state_ff)
            ST_SETTLE: begin
                if (settle_done) begin
                    nxt_state = ST_SELECT;
                end
            end
            ST_SELECT: begin
                if (!id_valid(id_sync)) begin
                    nxt_state = ST_ADDR_ERR;
                end else if (want_auto) begin
                    nxt_state = ST_DETECT;
                    nxt_rate = RATE_MIN;
                end else begin
                    nxt_state = ST_BOOT;
                    nxt_rate = fixed_rate;
                end
            end
            ST_DETECT: begin
                if (lock_ev) begin
                    nxt_state = ST_BOOT;
                end else if (retry_ev) begin
                    nxt_rate = rate_next_try;
                end
            end
            ST_BOOT: begin
                if (boot_tx_ready) begin
                    nxt_state = ST_PREOP;
                end
            end
            ST_PREOP: begin
                nxt_state = ST_PREOP;
            end
            ST_ADDR_ERR: begin
                nxt_state = ST_ADDR_ERR;
            end
            default: begin
                nxt_state = ST_SETTLE;
            end
        endcase
    end

    // state, rate and settle count are cleared on every reset; rate is then loaded only in select and detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_SETTLE;
            rate_ff <= RATE_AUTO;
            settle_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            rate_ff <= nxt_rate;
            settle_ff <= settle_done ? settle_ff : settle_ff + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_id_ff <= 7'h00;
            auto_ff <= 1'b0;
        end else if (in_select) begin
            node_id_ff <= id_sync;
            auto_ff <= want_auto;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dwell_cnt_ff <= 32'h0000_0000;
        end else if (!in_detect || retry_ev) begin
            dwell_cnt_ff <= 32'h0000_0000;
        end else begin
            dwell_cnt_ff <= dwell_cnt_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 1'b0;
        end else if (blink_tick) begin
            phase_ff <= !phase_ff;
        end
    end

    // link side outputs
    assign bit_rate_code = rate_ff;
    assign listen_only = in_detect;
    assign tx_enable = (state_ff == ST_BOOT) || (state_ff == ST_PREOP);
    assign boot_tx_valid = (state_ff == ST_BOOT);
    assign boot_tx_node_id = node_id_ff;
    assign preop_state = (state_ff == ST_PREOP);
    assign address_error_display = (state_ff == ST_ADDR_ERR);
    assign run_led = in_detect ? phase_ff : preop_state;
    assign fault_led = (in_detect || address_error_display) && !phase_ff;

    // apb slave, zero wait states
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_status = (paddr == OFF_STATUS);
    wire hit_istat = (paddr == OFF_IRQ_STATUS);
    wire hit_imask = (paddr == OFF_IRQ_MASK);
    wire hit_dwell = (paddr == OFF_DWELL);
    wire hit_any = hit_status || hit_istat || hit_imask || hit_dwell;

    wire [31:0] status_word = {15'h0000, auto_ff, 1'b0, state_ff, 1'b0, node_id_ff, rate_ff};
    wire [31:0] rd_mux = hit_status ? status_word :
                         hit_istat ? {28'h000_0000, irq_stat_ff} :
                         hit_imask ? {28'h000_0000, irq_mask_ff} :
                         hit_dwell ? dwell_ff : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_ff <= !hit_any;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel && penable && pslverr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= IRQ_MASK_RESET;
            dwell_ff <= DWELL_RESET;
        end else if (apb_wr) begin
            if (hit_imask) begin
                irq_mask_ff <= pwdata[IRQ_W-1:0];
            end
            if (hit_dwell) begin
                dwell_ff <= pwdata;
            end
        end
    end

    // a new event in the clearing cycle survives the write-one-to-clear
    wire [IRQ_W-1:0] irq_events = {retry_ev, addr_ev, boot_done, lock_ev};
    wire [IRQ_W-1:0] irq_clear = (apb_wr && hit_istat) ? pwdata[IRQ_W-1:0] : 4'h0;
    wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clear) | irq_events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 4'h0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // checks
    sequence seq_lock;
        in_detect && rx_frame_ok;
    endsequence

    sequence seq_boot_offer;
        boot_tx_valid && !listen_only;
    endsequence

    sequence seq_boot_taken;
        boot_tx_valid && boot_tx_ready;
    endsequence

    chk_tx_silent: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff != ST_BOOT && state_ff != ST_PREOP) |-> (!tx_enable && !boot_tx_valid))
        else $error("transmit active before the rate is known");

    chk_led_alternate: assert property (@(posedge pclk) disable iff (!presetn)
        in_detect |-> (run_led != fault_led))
        else $error("leds not alternating during detection");

    chk_lock_boot: assert property (@(posedge pclk) disable iff (!presetn)
        seq_lock |=> seq_boot_offer ##0 $stable(bit_rate_code))
        else $error("no boot-up offer after rate lock");

    chk_rate_step: assert property (@(posedge pclk) disable iff (!presetn)
        retry_ev |=> (bit_rate_code == (($past(bit_rate_code) == RATE_MAX) ? RATE_MIN
                                        : $past(bit_rate_code) + 4'h1)))
        else $error("detection did not move to the next rate");

    chk_rate_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_enable && $past(tx_enable)) |-> $stable(bit_rate_code))
        else $error("bit rate changed while running");

    chk_id_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff != ST_SELECT && state_ff != ST_SETTLE) |=> $stable(boot_tx_node_id))
        else $error("node id changed after start-up");

    chk_manual_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (in_select && id_valid(id_sync) && rate_manual(sel_sync))
            |=> (bit_rate_code == $past(sel_sync)) && boot_tx_valid)
        else $error("manual selection not applied");

    chk_old_fw: assert property (@(posedge pclk) disable iff (!presetn)
        (in_select && id_valid(id_sync) && sel_sync == RATE_AUTO && !auto_allowed)
            |=> (bit_rate_code == RATE_DEFAULT) && !listen_only)
        else $error("auto selection acted on old firmware");

    chk_id_range: assert property (@(posedge pclk) disable iff (!presetn)
        boot_tx_valid |-> (boot_tx_node_id >= NODE_ID_MIN && boot_tx_node_id <= NODE_ID_MAX))
        else $error("boot-up offered with an invalid node id");

    chk_addr_error: assert property (@(posedge pclk) disable iff (!presetn)
        (in_select && id_sync == 7'h00) |=> address_error_display && !tx_enable)
        else $error("node id zero not flagged");

    // the core may stall the boot-up frame; the offer and its id must hold meanwhile
    chk_boot_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (boot_tx_valid && !boot_tx_ready)
            |=> boot_tx_valid && $stable(boot_tx_node_id))
        else $error("boot-up offer withdrawn before it was taken");

    chk_boot_preop: assert property (@(posedge pclk) disable iff (!presetn)
        seq_boot_taken |=> preop_state && !boot_tx_valid && tx_enable)
        else $error("no pre-operational state after the boot-up frame");

    chk_detect_start: assert property (@(posedge pclk) disable iff (!presetn)
        (in_select && id_valid(id_sync) && want_auto)
            |=> listen_only && (bit_rate_code == RATE_MIN))
        else $error("detection did not start at the lowest rate");

    chk_fresh_start: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_SETTLE) |-> (bit_rate_code == RATE_AUTO) && !listen_only)
        else $error("a rate survived the power cycle");

    chk_addr_silent: assert property (@(posedge pclk) disable iff (!presetn)
        address_error_display |-> !listen_only && !tx_enable && !run_led)
        else $error("node with a bad address is not silent");

    chk_rate_legal: assert property (@(posedge pclk) disable iff (!presetn)
        tx_enable |-> rate_manual(bit_rate_code))
        else $error("transmitting without one of the eight rates");

endmodule : can_node_rate_and_id_setup

// ===== verification/can_bus_model.sv
`timescale 1ns/1ps
module can_bus_model #(
    parameter int FRAME_GAP = 6,
    parameter logic [6:0] PEER_ID = 7'h30
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic traffic_on,
    input wire logic [3:0] net_rate,
    input wire logic [3:0] ready_dly,
    input wire logic [3:0] bit_rate_code,
    input wire logic boot_tx_valid,
    input wire logic [6:0] boot_tx_node_id,
    output logic rx_frame_ok,
    output logic rx_frame_err,
    output logic boot_tx_ready,
    output logic id_clash
);
    int gap_cnt;
    logic [3:0] wait_cnt;
    // a configured peer already owns PEER_ID; the dut must never announce it too
    assign id_clash = boot_tx_valid && (boot_tx_node_id == PEER_ID);
    // frames only appear while a configured peer talks at net_rate
    wire frame_now = traffic_on && (gap_cnt == FRAME_GAP - 1);
    // combinational so a rate step at the same edge cannot mislabel a frame
    assign rx_frame_ok = frame_now && (bit_rate_code == net_rate);
    assign rx_frame_err = frame_now && (bit_rate_code != net_rate);
    assign boot_tx_ready = boot_tx_valid && (wait_cnt >= ready_dly);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 0;
            wait_cnt <= 4'h0;
        end else begin
            gap_cnt <= (gap_cnt == FRAME_GAP - 1) ? 0 : gap_cnt + 1;
            wait_cnt <= (boot_tx_valid && wait_cnt != 4'hF) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : can_bus_model

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import can_setup_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, id_clash;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] bit_rate_select, bit_rate_code, net_rate, ready_dly;
    logic [6:0] node_id_select, boot_tx_node_id;
    logic [15:0] fw_revision;
    logic rx_frame_ok, rx_frame_err, boot_tx_ready, listen_only, tx_enable, boot_tx_valid;
    logic preop_state, run_led, fault_led, address_error_display, traffic_on, seen_hi, seen_lo;
    int n_fail, checks_done;

    can_node_rate_and_id_setup #(.BLINK_CYCLES(8), .DWELL_RESET(32'h14)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .bit_rate_select(bit_rate_select), .node_id_select(node_id_select),
        .fw_revision(fw_revision), .rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err),
        .boot_tx_ready(boot_tx_ready), .bit_rate_code(bit_rate_code),
        .listen_only(listen_only), .tx_enable(tx_enable), .boot_tx_valid(boot_tx_valid),
        .boot_tx_node_id(boot_tx_node_id), .preop_state(preop_state), .run_led(run_led),
        .fault_led(fault_led), .address_error_display(address_error_display));
    can_bus_model bus (.pclk(pclk), .presetn(presetn), .traffic_on(traffic_on),
        .net_rate(net_rate), .ready_dly(ready_dly), .bit_rate_code(bit_rate_code),
        .boot_tx_valid(boot_tx_valid), .boot_tx_node_id(boot_tx_node_id),
        .rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err),
        .boot_tx_ready(boot_tx_ready), .id_clash(id_clash));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic timed_out;
        n_fail++;
        $display("BAD wait ran out of cycles");
        give_verdict();
    endtask : timed_out

    task automatic power_up(input logic [3:0] sel, input logic [6:0] id, input logic [15:0] fw);
        @(posedge pclk);
        presetn <= 1'b0;
        bit_rate_select <= sel;
        node_id_select <= id;
        fw_revision <= fw;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : power_up

    task automatic wait_on(input bit want_preop);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if ((want_preop ? preop_state : boot_tx_valid) === 1'b1) break;
        end
        if (i == 3000) timed_out();
    endtask : wait_on

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50) timed_out();
    endtask : apb

    // watches detection and address error every cycle
    always @(posedge pclk) begin
        if (presetn !== 1'b1) begin
            seen_hi <= 1'b0;
            seen_lo <= 1'b0;
        end else if (listen_only === 1'b1 || address_error_display === 1'b1) begin
            if (fault_led === 1'b1) seen_hi <= 1'b1;
            if (fault_led === 1'b0) seen_lo <= 1'b1;
        end
        if (listen_only === 1'b1) begin
            chk("tx_enable in detect", 32'h0, 32'(tx_enable));
            chk("boot_tx_valid in detect", 32'h0, 32'(boot_tx_valid));
            chk("leds alternate", 32'h1, 32'(run_led ^ fault_led));
        end
        if (boot_tx_valid === 1'b1) chk("unique node id", 32'h0, 32'(id_clash));
    end

    initial begin
        n_fail = 0;
        checks_done = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {bit_rate_select, node_id_select, fw_revision} = 27'h0;
        traffic_on = 1'b1;
        net_rate = 4'h5;
        ready_dly = 4'h0;
        for (int r = 1; r <= 8; r++) begin
            power_up(4'(r), 7'h05 + 7'(r), FW_AUTO_MIN);
            wait_on(1'b0);
            chk("fixed rate", 32'(r), 32'(bit_rate_code));
            chk("boot id", 32'h05 + 32'(r), 32'(boot_tx_node_id));
            chk("tx_enable at boot", 32'h1, 32'(tx_enable));
            wait_on(1'b1);
            chk("leds in preop", 32'h2, 32'({run_led, fault_led}));
        end
        bit_rate_select <= 4'h2;
        node_id_select <= 7'h40;
        repeat (20) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status after strap change", 32'h000060D8, rd);
        power_up(4'h9, 7'h21, FW_AUTO_MIN);
        wait_on(1'b0);
        chk("out of range code", 32'h6, 32'(bit_rate_code));
        power_up(4'h0, 7'h22, FW_AUTO_MIN - 16'h0001);
        wait_on(1'b0);
        chk("auto on old firmware", 32'h6, 32'(bit_rate_code));
        ready_dly <= 4'h5;
        power_up(4'h0, 7'h7E, FW_AUTO_MIN);
        wait_on(1'b0);
        chk("detected rate", 32'h5, 32'(bit_rate_code));
        chk("top id", 32'h7E, 32'(boot_tx_node_id));
        chk("both blink phases", 32'h3, 32'({seen_hi, seen_lo}));
        wait_on(1'b1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status auto", 32'h000167E5, rd);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk("irq status", 32'hB, rd);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, OFF_IRQ_MASK, 32'h2);
        // a write lands at the access edge and irq follows at once; the check samples one edge later
        @(posedge pclk);
        chk("irq unmasked", 32'h1, 32'(irq));
        apb(1'b1, OFF_IRQ_STATUS, 32'h2);
        @(posedge pclk);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk("irq status after clear", 32'h9, rd);
        apb(1'b0, OFF_DWELL, 32'h0);
        chk("dwell reset", 32'h14, rd);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped read", 32'h0, rd);
        traffic_on <= 1'b0;
        net_rate <= 4'h3;
        power_up(4'h0, 7'h10, FW_AUTO_MIN);
        @(posedge pclk);
        chk("no stored rate", 32'h0, 32'(bit_rate_code));
        repeat (600) @(posedge pclk);
        chk("silent bus keeps detecting", 32'h1, 32'(listen_only));
        traffic_on <= 1'b1;
        wait_on(1'b0);
        chk("fresh detection", 32'h3, 32'(bit_rate_code));
        for (int k = 0; k < 2; k++) begin
            power_up(4'h6, k == 0 ? 7'h00 : 7'h7F, FW_AUTO_MIN);
            repeat (320) @(posedge pclk);
            chk("address error", 32'h1, 32'(address_error_display));
            chk("no boot on bad id", 32'h0, 32'({boot_tx_valid, tx_enable, run_led}));
            chk("fault flashes", 32'h3, 32'({seen_hi, seen_lo}));
            apb(1'b0, OFF_IRQ_STATUS, 32'h0);
            chk("irq address error", 32'h4, rd);
        end
        give_verdict();
    end
endmodule : testbench
